// file: cmm_core_map.sv
// address generation and data space decoding for the core
// assumes sfr read data valid in the same cycle as sfr_rd, same clock
`include "cmm_params.svh"
module cmm_core_map (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // operand access request
  input wire logic req_valid,
  output logic req_ready,
  input wire cmm_pkg::cmm_mode_t req_mode,
  input wire logic req_write,
  input wire logic [7:0] req_field,
  input wire logic [7:0] req_wdata,
  // read answer
  output logic rd_valid_ff,
  output logic [7:0] rd_data_ff,
  // core state seen by the mapper
  input wire logic [7:0] program_status_word,
  input wire logic [7:0] accumulator,
  input wire logic [15:0] sixteen_bit_pointer,
  // stack pointer direct load
  input wire logic sp_load,
  input wire logic [7:0] sp_wdata,
  output logic [7:0] sp_ff,
  // program counter control
  input wire logic instr_start,
  input wire logic [1:0] instr_len,
  input wire logic [2:0] instr_cycles,
  output logic instr_done,
  input wire logic int_take,
  input wire logic [4:0] int_num,
  input wire logic jmp_indexed,
  input wire logic branch_load,
  input wire logic [15:0] branch_target,
  output logic [15:0] program_counter_ff,
  // code read port to on-chip flash
  output logic code_rd_ff,
  output logic [15:0] code_rd_addr_ff,
  // special function register port
  output logic sfr_rd_ff,
  output logic sfr_wr_ff,
  output logic sfr_bit_ff,
  output logic [2:0] sfr_bit_idx_ff,
  output logic [7:0] sfr_addr_ff,
  output logic [7:0] sfr_wdata_ff,
  input wire logic [7:0] sfr_rdata
);
  typedef enum logic [1:0] {
    CMM_ST_IDLE,
    CMM_ST_PTR,
    CMM_ST_RMW
  } cmm_state_t;
  cmm_state_t state_ff;
  cmm_pkg::cmm_kind_t s1_kind_ff, nxt_kind;
  logic s1_bit_ff, ptr_wr_ff, rmw_val_ff;
  logic acc_go, dec_sfr, dec_ram_wr, mem_we;
  logic [1:0] bank;
  logic [2:0] s1_bidx_ff, rmw_bidx_ff, cyc_left_ff;
  logic [7:0] s1_const_ff, ptr_wdata_ff, rmw_addr_ff;
  logic [7:0] dec_addr, mem_addr, mem_wdata, mem_rdata, rmw_byte, s1_byte;
  logic [15:0] idx_sum;
  assign bank = {program_status_word[`CMM_BANK_HI_BIT],
                 program_status_word[`CMM_BANK_LO_BIT]};
  assign req_ready = (state_ff == CMM_ST_IDLE);
  assign acc_go = req_valid && req_ready;
  assign instr_done = (cyc_left_ff == `CMM_CYC_MIN);
  // base plus accumulator, for table reads; indexed jump adds its own
  assign idx_sum = ((req_mode == cmm_pkg::CMM_MODE_CODE_PC)
                    ? program_counter_ff : sixteen_bit_pointer)
                   + {8'h00, accumulator};
  // first-cycle address decode
  always_comb begin
    dec_addr = 8'h00;
    dec_sfr = 1'b0;
    case (req_mode)
      cmm_pkg::CMM_MODE_DIRECT: begin
        dec_addr = req_field;
        dec_sfr = req_field[`CMM_UPPER_BIT];
      end
      cmm_pkg::CMM_MODE_REGISTER: begin
        dec_addr = {3'h0, bank, req_field[2:0]};
      end
      cmm_pkg::CMM_MODE_POINTER: begin
        dec_addr = {3'h0, bank, 2'h0, req_field[0]};
      end
      cmm_pkg::CMM_MODE_STACK: begin
        dec_addr = req_write ? sp_ff + 8'h01 : sp_ff;
      end
      cmm_pkg::CMM_MODE_BIT: begin
        dec_sfr = req_field[`CMM_UPPER_BIT];
        if (req_field[`CMM_UPPER_BIT]) begin
          dec_addr = {req_field[7:3], 3'h0};
        end else begin
          dec_addr = `CMM_BIT_AREA_BASE
                     + {4'h0, req_field[6:3]};
        end
      end
      default: dec_addr = 8'h00;
    endcase
  end
  // ram writes taken in the request cycle
  assign dec_ram_wr = acc_go && req_write && !dec_sfr
                      && (req_mode == cmm_pkg::CMM_MODE_DIRECT
                          || req_mode == cmm_pkg::CMM_MODE_REGISTER
                          || req_mode == cmm_pkg::CMM_MODE_STACK);
  // ram port steering; pointer targets reach all 256 bytes
  always_comb begin
    rmw_byte = mem_rdata;
    rmw_byte[rmw_bidx_ff] = rmw_val_ff;
    case (state_ff)
      CMM_ST_PTR: begin
        mem_addr = mem_rdata;
        mem_we = ptr_wr_ff;
        mem_wdata = ptr_wdata_ff;
      end
      CMM_ST_RMW: begin
        mem_addr = rmw_addr_ff;
        mem_we = 1'b1;
        mem_wdata = rmw_byte;
      end
      default: begin
        mem_addr = dec_addr;
        mem_we = dec_ram_wr;
        mem_wdata = req_wdata;
      end
    endcase
  end
  cmm_iram u_iram (
    .clk(clk),
    .addr(mem_addr),
    .we(mem_we),
    .wdata(mem_wdata),
    .rdata_ff(mem_rdata)
  );
  // what the second cycle returns
  always_comb begin
    nxt_kind = cmm_pkg::CMM_KIND_NONE;
    if (state_ff == CMM_ST_PTR) begin
      nxt_kind = ptr_wr_ff ? cmm_pkg::CMM_KIND_NONE
                           : cmm_pkg::CMM_KIND_RAM;
    end else if (acc_go && !req_write) begin
      case (req_mode)
        cmm_pkg::CMM_MODE_CONSTANT: nxt_kind = cmm_pkg::CMM_KIND_CONST;
        cmm_pkg::CMM_MODE_POINTER, cmm_pkg::CMM_MODE_CODE_SIXTEEN_BIT_POINTER,
        cmm_pkg::CMM_MODE_CODE_PC: nxt_kind = cmm_pkg::CMM_KIND_NONE;
        default: nxt_kind = dec_sfr ? cmm_pkg::CMM_KIND_SFR
                                    : cmm_pkg::CMM_KIND_RAM;
      endcase
    end
  end
  // sequencing of two-cycle accesses
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= CMM_ST_IDLE;
    end else begin
      case (state_ff)
        CMM_ST_IDLE: begin
          if (acc_go && req_mode == cmm_pkg::CMM_MODE_POINTER) begin
            state_ff <= CMM_ST_PTR;
          end else if (acc_go && req_write && !dec_sfr
                       && req_mode == cmm_pkg::CMM_MODE_BIT) begin
            state_ff <= CMM_ST_RMW;
          end
        end
        default: state_ff <= CMM_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_wr_ff <= 1'b0;
      ptr_wdata_ff <= 8'h00;
      rmw_addr_ff <= 8'h00;
      rmw_bidx_ff <= 3'h0;
      rmw_val_ff <= 1'b0;
    end else if (acc_go) begin
      ptr_wr_ff <= req_write;
      ptr_wdata_ff <= req_wdata;
      rmw_addr_ff <= dec_addr;
      rmw_bidx_ff <= req_field[2:0];
      rmw_val_ff <= req_wdata[0];
    end
  end
  // read answer pipeline
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_kind_ff <= cmm_pkg::CMM_KIND_NONE;
      s1_bit_ff <= 1'b0;
      s1_bidx_ff <= 3'h0;
      s1_const_ff <= 8'h00;
    end else begin
      s1_kind_ff <= nxt_kind;
      s1_bit_ff <= acc_go && req_mode == cmm_pkg::CMM_MODE_BIT;
      s1_bidx_ff <= req_field[2:0];
      s1_const_ff <= req_field;
    end
  end

  always_comb begin
    case (s1_kind_ff)
      cmm_pkg::CMM_KIND_SFR: s1_byte = sfr_rdata;
      cmm_pkg::CMM_KIND_CONST: s1_byte = s1_const_ff;
      default: s1_byte = mem_rdata;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff <= 8'h00;
    end else begin
      rd_valid_ff <= (s1_kind_ff != cmm_pkg::CMM_KIND_NONE);
      if (s1_kind_ff != cmm_pkg::CMM_KIND_NONE) begin
        rd_data_ff <= s1_bit_ff ? {7'h00, s1_byte[s1_bidx_ff]}
                                : s1_byte;
      end
    end
  end
  // special function register strobes, direct and bit modes only
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rd_ff <= 1'b0;
      sfr_wr_ff <= 1'b0;
      sfr_bit_ff <= 1'b0;
      sfr_bit_idx_ff <= 3'h0;
      sfr_addr_ff <= 8'h00;
      sfr_wdata_ff <= 8'h00;
    end else begin
      sfr_rd_ff <= acc_go && dec_sfr && !req_write;
      sfr_wr_ff <= acc_go && dec_sfr && req_write;
      sfr_bit_ff <= acc_go && dec_sfr
                    && req_mode == cmm_pkg::CMM_MODE_BIT;
      if (acc_go && dec_sfr) begin
        sfr_bit_idx_ff <= req_field[2:0];
        sfr_addr_ff <= dec_addr;
        sfr_wdata_ff <= req_wdata;
      end
    end
  end
  // table reads from code space; writes there are dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      code_rd_ff <= 1'b0;
      code_rd_addr_ff <= `CMM_PC_RESET;
    end else begin
      code_rd_ff <= acc_go && !req_write
                    && (req_mode == cmm_pkg::CMM_MODE_CODE_SIXTEEN_BIT_POINTER
                        || req_mode == cmm_pkg::CMM_MODE_CODE_PC);
      if (acc_go && !req_write) begin
        code_rd_addr_ff <= idx_sum;
      end
    end
  end
  // stack pointer
  always_ff @(posedge clk) begin
    if (rst) begin
      sp_ff <= `CMM_SP_RESET;
    end else if (acc_go && req_mode == cmm_pkg::CMM_MODE_STACK) begin
      sp_ff <= req_write ? sp_ff + 8'h01 : sp_ff - 8'h01;
    end else if (sp_load) begin
      sp_ff <= sp_wdata;
    end
  end
  // program counter
  always_ff @(posedge clk) begin
    if (rst) begin
      program_counter_ff <= `CMM_PC_RESET;
    end else if (int_take) begin
      program_counter_ff <= `CMM_VEC_BASE
                            + {8'h00, int_num, 3'h0};
    end else if (jmp_indexed) begin
      program_counter_ff <= sixteen_bit_pointer
                            + {8'h00, accumulator};
    end else if (branch_load) begin
      program_counter_ff <= branch_target;
    end else if (instr_start) begin
      program_counter_ff <= program_counter_ff
                            + {14'h0000, instr_len};
    end
  end
  // instruction length in clocks
  always_ff @(posedge clk) begin
    if (rst) begin
      cyc_left_ff <= 3'h0;
    end else if (instr_start) begin
      cyc_left_ff <= (instr_cycles == 3'h0) ? `CMM_CYC_MIN
                                            : instr_cycles;
    end else if (cyc_left_ff != 3'h0) begin
      cyc_left_ff <= cyc_left_ff - 3'h1;
    end
  end
endmodule // cmm_core_map

// file: cmm_params.svh
// constants for the core memory address mapping block
// assumes one clock, synchronous active-high reset
//
// What this block does
// - instruction length counted in clocks, 1 to 7
// - direct address is 8-bit, internal only
// - pointers are work registers, stack, 16-bit pointer
// - register mode picks bank register by 3 bits
// - indexed reads code at base plus accumulator
// - indexed jump loads base plus accumulator
// - code space read-only, on-chip, 64K
// - separate code and 256-byte data spaces
// - program counter starts at zero after reset
// - interrupt vectors at 0003H, eight bytes apart
// - above 7FH: direct to SFR, pointer to RAM
// - lowest 32 bytes form four register banks
// - 16 bytes above banks are bit addressable
// - SFR direct only; 16 of them bit addressable
// - status bits 4 and 3 select the bank
// - stack pointer pre-increments, resets to 07H
`ifndef CMM_PARAMS_SVH
`define CMM_PARAMS_SVH
`define CMM_PC_RESET 16'h0000
`define CMM_SP_RESET 8'h07
`define CMM_VEC_BASE 16'h0003
`define CMM_UPPER_BIT 7
`define CMM_BANK_HI_BIT 4
`define CMM_BANK_LO_BIT 3
`define CMM_BIT_AREA_BASE 8'h20
`define CMM_CYC_MIN 3'h1
`define CMM_RAM_DEPTH 256
`endif

// file: cmm_pkg.sv
// types shared by the address mapping block
// assumes nothing beyond the constants header
package cmm_pkg;
  typedef enum logic [2:0] {
    CMM_MODE_DIRECT,
    CMM_MODE_POINTER,
    CMM_MODE_STACK,
    CMM_MODE_REGISTER,
    CMM_MODE_CONSTANT,
    CMM_MODE_BIT,
    CMM_MODE_CODE_SIXTEEN_BIT_POINTER,
    CMM_MODE_CODE_PC
  } cmm_mode_t;
  typedef enum logic [1:0] {
    CMM_KIND_NONE,
    CMM_KIND_RAM,
    CMM_KIND_SFR,
    CMM_KIND_CONST
  } cmm_kind_t;
endpackage

// file: cmm_iram.sv
// 256-byte internal data ram, one port, registered read data
// assumes address, write enable and data from the same clock
`include "cmm_params.svh"
module cmm_iram (
  // clock
  input wire logic clk,
  // port
  input wire logic [7:0] addr,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata_ff
);
  logic [7:0] mem [`CMM_RAM_DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata_ff <= mem[addr];
  end
endmodule // cmm_iram

// file: cmm_map_sva.sv
// assertions on the address mapping ports
// assumes one clock and a synchronous active-high reset
module cmm_map_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // operand requests
  input wire logic req_valid,
  input wire logic req_ready,
  input wire cmm_pkg::cmm_mode_t req_mode,
  input wire logic req_write,
  input wire logic [7:0] req_field,
  input wire logic [7:0] accumulator,
  input wire logic [15:0] sixteen_bit_pointer,
  input wire logic [7:0] sp_ff,
  // program counter
  input wire logic instr_start,
  input wire logic [2:0] instr_cycles,
  input wire logic instr_done,
  input wire logic int_take,
  input wire logic [4:0] int_num,
  input wire logic jmp_indexed,
  input wire logic [15:0] program_counter_ff,
  // code and sfr ports
  input wire logic code_rd_ff,
  input wire logic [15:0] code_rd_addr_ff,
  input wire logic sfr_rd_ff,
  input wire logic sfr_wr_ff,
  input wire logic [7:0] sfr_addr_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  logic take;
  assign take = req_valid && req_ready;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_pc_rst;
    $fell(rst) |-> program_counter_ff == 16'h0000;
  endproperty
  a_pc_rst: assert property (p_pc_rst) else $error("pc not zero");
  property p_vec;
    int_take |=> program_counter_ff == {8'h00, $past(int_num), 3'h3};
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_jmp;
    jmp_indexed && !int_take |=> program_counter_ff ==
      $past(sixteen_bit_pointer) + 16'($past(accumulator));
  endproperty
  a_jmp: assert property (p_jmp) else $error("bad jump");
  property p_dir_sfr;
    take && req_mode == cmm_pkg::CMM_MODE_DIRECT && !req_write &&
      req_field[7] |=> sfr_rd_ff && sfr_addr_ff == $past(req_field);
  endproperty
  a_dir_sfr: assert property (p_dir_sfr) else $error("no sfr read");
  property p_nosfr;
    take && req_mode inside {cmm_pkg::CMM_MODE_POINTER,
      cmm_pkg::CMM_MODE_REGISTER, cmm_pkg::CMM_MODE_STACK}
      |=> !sfr_rd_ff && !sfr_wr_ff;
  endproperty
  a_nosfr: assert property (p_nosfr) else $error("sfr reached");
  property p_code;
    take && req_mode == cmm_pkg::CMM_MODE_CODE_SIXTEEN_BIT_POINTER && !req_write
      |=> code_rd_ff && code_rd_addr_ff ==
      $past(sixteen_bit_pointer) + 16'($past(accumulator));
  endproperty
  a_code: assert property (p_code) else $error("bad code read");
  property p_push;
    take && req_mode == cmm_pkg::CMM_MODE_STACK && req_write
      |=> sp_ff == $past(sp_ff) + 8'h01;
  endproperty
  a_push: assert property (p_push) else $error("bad push");
  property p_done;
    instr_start && instr_cycles == 3'h3 ##1 !instr_start [*2]
      |-> ##1 instr_done;
  endproperty
  a_done: assert property (p_done) else $error("late done");
  c_vec: cover property (int_take);
  c_ptr: cover property (take && req_mode == cmm_pkg::CMM_MODE_POINTER);
  c_sfr: cover property (sfr_wr_ff);
endmodule // cmm_map_sva

// file: cmm_sfr_model.sv
// peripheral register side answering sfr reads
// assumes read data is taken in the cycle the read pulse is high
module cmm_sfr_model (
  // clock
  input wire logic clk,
  // sfr port
  input wire logic rd,
  input wire logic [7:0] addr,
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_ff;
  // off-cycle data flips every cycle so stale bytes never match
  assign rdata = rd ? addr ^ 8'hA5 : ~last_ff;
  always_ff @(posedge clk) last_ff <= rdata;
endmodule // cmm_sfr_model

// file: tb_top.sv
// self-checking bench for the address mapping block
// assumes the sfr model answers reads in the pulse cycle
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, req_valid = 0, req_write = 0, sp_load = 0;
  logic instr_start = 0, int_take = 0, jmp_indexed = 0, branch_load = 0;
  logic [7:0] req_field = 0, req_wdata = 0, program_status_word = 0;
  logic [7:0] accumulator = 0, sp_wdata = 0, rdat, c1a, a, d;
  logic [15:0] sixteen_bit_pointer = 0, branch_target = 0, c1c, epc;
  logic [1:0] instr_len = 2'h2;
  logic [2:0] instr_cycles = 3'h1;
  logic [4:0] int_num = 0;
  logic [5:0] c1;
  logic rv;
  cmm_pkg::cmm_mode_t req_mode = cmm_pkg::CMM_MODE_DIRECT;
  logic req_ready, rd_valid_ff, instr_done, code_rd_ff, sfr_rd_ff;
  logic sfr_wr_ff, sfr_bit_ff;
  logic [2:0] sfr_bit_idx_ff;
  logic [7:0] rd_data_ff, sp_ff, sfr_addr_ff, sfr_wdata_ff, sfr_rdata;
  logic [15:0] program_counter_ff, code_rd_addr_ff;
  logic [7:0] mem [256];
  logic [31:0] rnd = 32'h1DF880E1;
  int fail_count = 0, n_compared = 0, cyc = 0, i, k;
  cmm_core_map dut (
    .clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_mode(req_mode), .req_write(req_write), .req_field(req_field),
    .req_wdata(req_wdata), .rd_valid_ff(rd_valid_ff),
    .rd_data_ff(rd_data_ff), .program_status_word(program_status_word),
    .accumulator(accumulator), .sixteen_bit_pointer(sixteen_bit_pointer),
    .sp_load(sp_load), .sp_wdata(sp_wdata), .sp_ff(sp_ff),
    .instr_start(instr_start), .instr_len(instr_len),
    .instr_cycles(instr_cycles), .instr_done(instr_done),
    .int_take(int_take), .int_num(int_num), .jmp_indexed(jmp_indexed),
    .branch_load(branch_load), .branch_target(branch_target),
    .program_counter_ff(program_counter_ff), .code_rd_ff(code_rd_ff),
    .code_rd_addr_ff(code_rd_addr_ff), .sfr_rd_ff(sfr_rd_ff),
    .sfr_wr_ff(sfr_wr_ff), .sfr_bit_ff(sfr_bit_ff),
    .sfr_bit_idx_ff(sfr_bit_idx_ff), .sfr_addr_ff(sfr_addr_ff),
    .sfr_wdata_ff(sfr_wdata_ff), .sfr_rdata(sfr_rdata));
  cmm_sfr_model u_sfr (.clk(clk), .rd(sfr_rd_ff), .addr(sfr_addr_ff),
    .rdata(sfr_rdata));
  initial forever #20 clk = ~clk;
  function automatic logic [7:0] nx();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd[7:0];
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task end_sim();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task acc(input cmm_pkg::cmm_mode_t m, input logic w,
           input logic [7:0] f, input logic [7:0] wd);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req_mode <= m;
    req_write <= w;
    req_field <= f;
    req_wdata <= wd;
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    c1 = {sfr_rd_ff, sfr_wr_ff, sfr_bit_ff, sfr_bit_idx_ff};
    c1a = sfr_addr_ff;
    c1c = code_rd_addr_ff;
    for (n = 0; n < 3 && rd_valid_ff !== 1'b1; n++) @(negedge clk);
    rdat = rd_data_ff;
    rv = rd_valid_ff;
  endtask
  task pev(input logic [3:0] ev, input logic [4:0] n);
    @(posedge clk);
    {int_take, jmp_indexed, branch_load, instr_start} <= ev;
    int_num <= n;
    instr_cycles <= n[2:0];
    @(posedge clk);
    {int_take, jmp_indexed, branch_load, instr_start} <= 4'h0;
    @(negedge clk);
  endtask
  task rnd_in();
    @(posedge clk);
    sixteen_bit_pointer <= {nx(), nx()};
    accumulator <= nx();
    branch_target <= {nx(), nx()};
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(program_counter_ff, 16'h0000);
    chk(16'(sp_ff), 16'h0007);
    for (i = 0; i < 24; i++) begin
      a = nx() & 8'h7F;
      mem[a] = nx();
      acc(cmm_pkg::CMM_MODE_DIRECT, 1'b1, a, mem[a]);
      chk(16'(rv), 16'h0000);
      acc(cmm_pkg::CMM_MODE_DIRECT, 1'b0, a, 8'h00);
      chk(16'(rdat), 16'(mem[a]));
      chk(16'(rv), 16'h0001);
    end
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      program_status_word <= {3'h0, i[1:0], 3'h0};
      a = nx() & 8'h07;
      d = nx();
      acc(cmm_pkg::CMM_MODE_REGISTER, 1'b1, a, d);
      acc(cmm_pkg::CMM_MODE_DIRECT, 1'b0, {i[4:0], 3'h0} + a, 8'h00);
      chk(16'(rdat), 16'(d));
    end
    acc(cmm_pkg::CMM_MODE_DIRECT, 1'b1, 8'h19, 8'h90);
    d = nx();
    acc(cmm_pkg::CMM_MODE_POINTER, 1'b1, 8'h01, d);
    acc(cmm_pkg::CMM_MODE_POINTER, 1'b0, 8'h01, 8'h00);
    chk(16'(rdat), 16'(d));
    acc(cmm_pkg::CMM_MODE_DIRECT, 1'b0, 8'h90, 8'h00);
    chk(16'(rdat), 16'h0035);
    d = nx();
    acc(cmm_pkg::CMM_MODE_CONSTANT, 1'b0, d, 8'h00);
    chk(16'(rdat), 16'(d));
    for (i = 0; i < 6; i++) begin
      a = nx() & 8'h7F;
      acc(cmm_pkg::CMM_MODE_DIRECT, 1'b1, 8'h20 + 8'(a[6:3]), 8'h00);
      acc(cmm_pkg::CMM_MODE_BIT, 1'b1, a, 8'h01);
      acc(cmm_pkg::CMM_MODE_DIRECT, 1'b0, 8'h20 + 8'(a[6:3]), 8'h00);
      chk(16'(rdat), 16'h0001 << a[2:0]);
      acc(cmm_pkg::CMM_MODE_BIT, 1'b0, a, 8'h00);
      chk(16'(rdat), 16'h0001);
      acc(cmm_pkg::CMM_MODE_BIT, 1'b0, a ^ 8'h01, 8'h00);
      chk(16'(rdat), 16'h0000);
      a = nx() | 8'h80;
      acc(cmm_pkg::CMM_MODE_BIT, 1'b1, a, 8'h01);
      chk({10'h000, c1}, {13'h0003, a[2:0]});
      chk(16'(c1a), {8'h00, a[7:3], 3'h0});
      chk(16'(sfr_wdata_ff), 16'h0001);
    end
    @(posedge clk);
    sp_load <= 1'b1;
    sp_wdata <= 8'h40;
    @(posedge clk);
    sp_load <= 1'b0;
    d = nx();
    acc(cmm_pkg::CMM_MODE_STACK, 1'b1, 8'h00, d);
    chk(16'(sp_ff), 16'h0041);
    acc(cmm_pkg::CMM_MODE_STACK, 1'b0, 8'h00, 8'h00);
    chk(16'(rdat), 16'(d));
    for (i = 0; i < 4; i++) begin
      pev(4'hE, 5'(nx()));
      chk(program_counter_ff, {8'h00, int_num, 3'h3});
      rnd_in();
      acc(cmm_pkg::CMM_MODE_CODE_SIXTEEN_BIT_POINTER, 1'b0, 8'h00, 8'h00);
      chk(c1c, sixteen_bit_pointer + 16'(accumulator));
      pev(4'h4, 5'h00);
      chk(program_counter_ff, sixteen_bit_pointer + 16'(accumulator));
      pev(4'h2, 5'h00);
      epc = branch_target;
      acc(cmm_pkg::CMM_MODE_CODE_PC, 1'b0, 8'h00, 8'h00);
      chk(c1c, epc + 16'(accumulator));
    end
    for (i = 0; i < 8; i++) begin
      pev(4'h1, i[4:0]);
      epc = epc + 16'h0002;
      chk(program_counter_ff, epc);
      for (k = 1; k < 9 && instr_done !== 1'b1; k++) @(negedge clk);
      chk(16'(k), (i == 0) ? 16'h0001 : 16'(i));
    end
    end_sim();
  end
endmodule // tb_top
bind cmm_core_map cmm_map_sva u_sva (
  .clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
  .req_mode(req_mode), .req_write(req_write), .req_field(req_field),
  .accumulator(accumulator), .sixteen_bit_pointer(sixteen_bit_pointer),
  .sp_ff(sp_ff), .instr_start(instr_start), .instr_cycles(instr_cycles),
  .instr_done(instr_done), .int_take(int_take), .int_num(int_num),
  .jmp_indexed(jmp_indexed), .program_counter_ff(program_counter_ff),
  .code_rd_ff(code_rd_ff), .code_rd_addr_ff(code_rd_addr_ff),
  .sfr_rd_ff(sfr_rd_ff), .sfr_wr_ff(sfr_wr_ff), .sfr_addr_ff(sfr_addr_ff));
